/* File: etc_top.sv */
// module: transmit control and statistics with axi4-lite register file
//
// Summary of operation
// - local fault request sends fault words, beats remote
// - remote fault request sends remote fault words
// - force idle sends only idle words once a packet under way is finished
// - custom preamble replaces standard preamble when enabled
// - ignore-checksum matters only with insertion disabled
// - bad checksum counted good only when ignoring
// - bad checksum flagged, packet passed unchanged
// - total packets pulses once per packet
// - five-bit bytes sent this cycle
// - good packets pulses once per good packet
// - good bytes nonzero only at good packet end
// - at most one bin per packet, none below 64 or above 1522 bytes; 64, 65-127, 128-255
// - bins 256-511 and 512-1023
// - bins 1024-1518 and 1519-1522
// - insertion appends checksum, setting fixed within packet
// - bad checksum stat only above 64 bytes
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module etc_top #(
  parameter int DATA_W = 128
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // axi4-lite register bus
  input  wire logic [7:0]          i_awaddr,
  input  wire logic                i_awvalid,
  output logic                     o_awready,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output logic                     o_wready,
  output logic [1:0]               o_bresp,
  output logic                     o_bvalid,
  input  wire logic                i_bready,
  input  wire logic [7:0]          i_araddr,
  input  wire logic                i_arvalid,
  output logic                     o_arready,
  output logic [31:0]              o_rdata,
  output logic [1:0]               o_rresp,
  output logic                     o_rvalid,
  input  wire logic                i_rready,
  // client transmit stream
  input  wire logic                i_s_valid,
  output logic                     o_s_ready,
  input  wire logic [DATA_W-1:0]   i_s_data,
  input  wire logic [DATA_W/8-1:0] i_s_keep,
  input  wire logic                i_s_last,
  // toward the pcs
  output etc_pkg::etc_code_t       o_tx_code,
  output logic [DATA_W-1:0]        o_tx_data,
  output logic [DATA_W/8-1:0]      o_tx_keep,
  output logic                     o_tx_sop,
  output logic                     o_tx_last,
  output logic [55:0]              o_tx_preamble,
  output logic                     o_tx_fcs_append,
  output logic [31:0]              o_tx_fcs,
  output logic                     o_tx_fcs_stomped,
  // statistics and interrupt
  output etc_pkg::etc_stat_t       o_stat,
  output logic                     o_irq
);
  localparam int NB = DATA_W / 8;

  initial begin
    if (DATA_W % 8 != 0 || NB < 1 || NB > 16) begin
      $error("etc_top: DATA_W must be 8 to 128 in whole bytes");
    end
  end

  // ---------------------------------------------------------------- registers
  logic [etc_pkg::CTRL_W-1:0]   ctrl;
  logic [31:0]                  pre_lo;
  logic [etc_pkg::PRE_HI_W-1:0] pre_hi;
  logic [etc_pkg::EVT_W-1:0]    status;
  logic [etc_pkg::EVT_W-1:0]    mask;

  logic        wr;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        rd;
  logic [7:0]  rd_addr;
  logic        wr_err;
  logic        rd_err;
  logic [31:0] rd_data;

  etc_axil #(
    .AW (8)
  ) u_axil (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr      (wr),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd      (rd),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  // write decode; status and state are read only
  wire wr_ctrl   = wr && wr_addr == etc_pkg::ADDR_CTRL;
  wire wr_pre_lo = wr && wr_addr == etc_pkg::ADDR_PRE_LO;
  wire wr_pre_hi = wr && wr_addr == etc_pkg::ADDR_PRE_HI;
  wire wr_mask   = wr && wr_addr == etc_pkg::ADDR_MASK;
  assign wr_err  = wr && !(wr_ctrl || wr_pre_lo || wr_pre_hi || wr_mask
                           || wr_addr == etc_pkg::ADDR_STATUS
                           || wr_addr == etc_pkg::ADDR_STATE);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wire [31:0] ctrl_w   = merge({26'h0000000, ctrl}, wr_data, wr_strb);
  wire [31:0] pre_lo_w = merge(pre_lo, wr_data, wr_strb);
  wire [31:0] pre_hi_w = merge({8'h00, pre_hi}, wr_data, wr_strb);
  wire [31:0] mask_w   = merge({30'h00000000, mask}, wr_data, wr_strb);

  // state visible to software
  logic in_pkt;

  wire rd_status = rd && rd_addr == etc_pkg::ADDR_STATUS;
  assign rd_err  = rd && !(rd_addr == etc_pkg::ADDR_CTRL || rd_addr == etc_pkg::ADDR_PRE_LO
                           || rd_addr == etc_pkg::ADDR_PRE_HI || rd_status
                           || rd_addr == etc_pkg::ADDR_MASK || rd_addr == etc_pkg::ADDR_STATE);
  assign rd_data =
      (rd_addr == etc_pkg::ADDR_CTRL)   ? {26'h0000000, ctrl} :
      (rd_addr == etc_pkg::ADDR_PRE_LO) ? pre_lo :
      (rd_addr == etc_pkg::ADDR_PRE_HI) ? {8'h00, pre_hi} :
      (rd_addr == etc_pkg::ADDR_STATUS) ? {30'h00000000, status} :
      (rd_addr == etc_pkg::ADDR_MASK)   ? {30'h00000000, mask} :
      (rd_addr == etc_pkg::ADDR_STATE)  ? {29'h00000000, o_tx_code, in_pkt} :
                                          32'h00000000;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl   <= etc_pkg::CTRL_RESET;
      pre_lo <= etc_pkg::PRE_STD[31:0];
      pre_hi <= etc_pkg::PRE_STD[55:32];
      mask   <= etc_pkg::MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_w[etc_pkg::CTRL_W-1:0];
      end
      if (wr_pre_lo) begin
        pre_lo <= pre_lo_w;
      end
      if (wr_pre_hi) begin
        pre_hi <= pre_hi_w[etc_pkg::PRE_HI_W-1:0];
      end
      if (wr_mask) begin
        mask <= mask_w[etc_pkg::EVT_W-1:0];
      end
    end
  end

  wire c_lfi    = ctrl[etc_pkg::CTRL_LFI_BIT];
  wire c_rfi    = ctrl[etc_pkg::CTRL_RFI_BIT];
  wire c_idle   = ctrl[etc_pkg::CTRL_IDLE_BIT];
  wire c_cpre   = ctrl[etc_pkg::CTRL_CPRE_BIT];
  wire c_fcsins = ctrl[etc_pkg::CTRL_FCSINS_BIT];
  wire c_ignfcs = ctrl[etc_pkg::CTRL_IGNFCS_BIT];

  // ---------------------------------------------------------------- stream
  // a new packet may start only when no fault or idle word is forced;
  // a packet already under way is finished so the wire never sees a torn frame
  // ready is a flop, so it is fed from next-cycle ctrl and packet state
  wire [etc_pkg::CTRL_W-1:0] next_ctrl = wr_ctrl ? ctrl_w[etc_pkg::CTRL_W-1:0] : ctrl;
  wire hold_off = |next_ctrl[etc_pkg::CTRL_IDLE_BIT:etc_pkg::CTRL_LFI_BIT];
  wire beat = i_s_valid & o_s_ready;
  wire sop  = beat & ~in_pkt;
  wire eop  = beat & i_s_last;

  // insertion mode latched at the first word and kept for the packet
  logic pkt_ins;
  logic pkt_ign;
  wire  cur_ins = in_pkt ? pkt_ins : c_fcsins;
  wire  cur_ign = in_pkt ? pkt_ign : c_ignfcs;

  logic [31:0] crc;
  logic [31:0] crc_next;
  etc_crc32 #(
    .NBYTES (NB)
  ) u_crc (
    .i_crc  (in_pkt ? crc : etc_pkg::CRC_INIT),
    .i_data (i_s_data),
    .i_keep (i_s_keep),
    .o_crc  (crc_next)
  );

  // bytes in this beat
  function automatic logic [4:0] count_keep(input logic [NB-1:0] k);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < NB; i++) begin
      n = n + {4'h0, k[i]};
    end
    return n;
  endfunction : count_keep

  logic [13:0] len;
  wire  [4:0]  beat_bytes = count_keep(i_s_keep);
  wire  [4:0]  fcs_add    = (eop && cur_ins) ? 5'(etc_pkg::FCS_BYTES) : 5'h00;
  wire  [13:0] len_run    = (in_pkt ? len : 14'h0000) + {9'h000, beat_bytes};
  wire  [13:0] pkt_len    = len_run + {9'h000, fcs_add};

  // pass-through frames carry their own checksum; check the residue
  wire fcs_bad  = eop && !cur_ins && crc_next != etc_pkg::CRC_RESIDUE;
  wire pkt_good = !fcs_bad || cur_ign;
  wire bad_stat = fcs_bad && pkt_len > etc_pkg::LEN_64;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_pkt  <= 1'b0;
      pkt_ins <= 1'b0;
      pkt_ign <= 1'b0;
      crc     <= etc_pkg::CRC_INIT;
      len     <= 14'h0000;
    end else if (beat) begin
      in_pkt <= ~i_s_last;
      crc    <= crc_next;
      len    <= len_run;
      if (sop) begin
        pkt_ins <= c_fcsins;
        pkt_ign <= c_ignfcs;
      end
    end
  end

  // code word: idle forcing outranks fault words, local beats remote
  wire etc_pkg::etc_code_t next_code =
      beat   ? etc_pkg::ETC_CODE_DATA :
      c_idle ? etc_pkg::ETC_CODE_IDLE :
      c_lfi  ? etc_pkg::ETC_CODE_LFI :
      c_rfi  ? etc_pkg::ETC_CODE_RFI :
               etc_pkg::ETC_CODE_IDLE;

  wire [55:0] next_pre = c_cpre ? {pre_hi, pre_lo} : etc_pkg::PRE_STD;

  // data is forwarded exactly as supplied; only sideband says what to append
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tx_code        <= etc_pkg::ETC_CODE_IDLE;
      o_s_ready        <= 1'b1;
      o_tx_data        <= '0;
      o_tx_keep        <= '0;
      o_tx_sop         <= 1'b0;
      o_tx_last        <= 1'b0;
      o_tx_preamble    <= etc_pkg::PRE_STD;
      o_tx_fcs_append  <= 1'b0;
      o_tx_fcs         <= 32'h00000000;
      o_tx_fcs_stomped <= 1'b0;
    end else begin
      o_tx_code        <= next_code;
      o_s_ready        <= (beat ? ~i_s_last : in_pkt) | ~hold_off;
      o_tx_data        <= beat ? i_s_data : '0;
      o_tx_keep        <= beat ? i_s_keep : '0;
      o_tx_sop         <= sop;
      o_tx_last        <= eop;
      o_tx_fcs_append  <= eop && cur_ins;
      o_tx_fcs         <= (eop && cur_ins) ? ~crc_next : 32'h00000000;
      o_tx_fcs_stomped <= fcs_bad;
      if (sop) begin
        o_tx_preamble <= next_pre;
      end
    end
  end

  // ---------------------------------------------------------------- statistics
  wire in_64    = pkt_len == etc_pkg::LEN_64;
  wire in_127   = pkt_len > etc_pkg::LEN_64 && pkt_len <= etc_pkg::LEN_127;
  wire in_255   = pkt_len > etc_pkg::LEN_127 && pkt_len <= etc_pkg::LEN_255;
  wire in_511   = pkt_len > etc_pkg::LEN_255 && pkt_len <= etc_pkg::LEN_511;
  wire in_1023  = pkt_len > etc_pkg::LEN_511 && pkt_len <= etc_pkg::LEN_1023;
  wire in_1518  = pkt_len > etc_pkg::LEN_1023 && pkt_len <= etc_pkg::LEN_1518;
  wire in_1522  = pkt_len > etc_pkg::LEN_1518 && pkt_len <= etc_pkg::LEN_1522;

  etc_pkg::etc_stat_t next_stat;
  always_comb begin
    next_stat               = '0;
    next_stat.total_bytes   = beat ? beat_bytes + fcs_add : 5'h00;
    next_stat.total_packets = eop;
    next_stat.good_packets  = eop && pkt_good;
    next_stat.good_bytes    = (eop && pkt_good) ? pkt_len : 14'h0000;
    next_stat.bad_fcs       = bad_stat;
    next_stat.bin_64        = eop && in_64;
    next_stat.bin_65_127    = eop && in_127;
    next_stat.bin_128_255   = eop && in_255;
    next_stat.bin_256_511   = eop && in_511;
    next_stat.bin_512_1023  = eop && in_1023;
    next_stat.bin_1024_1518 = eop && in_1518;
    next_stat.bin_1519_1522 = eop && in_1522;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_stat <= '0;
    end else begin
      o_stat <= next_stat;
    end
  end

  // ---------------------------------------------------------------- interrupt
  // set wins over the clear a status read makes in the same cycle
  wire [etc_pkg::EVT_W-1:0] evt = {bad_stat, eop};
  wire [etc_pkg::EVT_W-1:0] next_status = (rd_status ? '0 : status) | evt;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status <= '0;
      o_irq  <= 1'b0;
    end else begin
      status <= next_status;
      o_irq  <= |(next_status & mask);
    end
  end
endmodule : etc_top
`default_nettype wire

/* File: etc_pkg.sv */
// package: constants and types of the transmit control and statistics block
package etc_pkg;
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PRE_LO = 8'h04;
  localparam logic [7:0] ADDR_PRE_HI = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_STATE  = 8'h14;

  // control register fields
  localparam int CTRL_LFI_BIT    = 0;
  localparam int CTRL_RFI_BIT    = 1;
  localparam int CTRL_IDLE_BIT   = 2;
  localparam int CTRL_CPRE_BIT   = 3;
  localparam int CTRL_FCSINS_BIT = 4;
  localparam int CTRL_IGNFCS_BIT = 5;
  localparam int CTRL_W          = 6;
  localparam logic [5:0] CTRL_RESET = 6'h10;

  // status / mask fields
  localparam int EVT_PKT_BIT = 0;
  localparam int EVT_BAD_BIT = 1;
  localparam int EVT_W       = 2;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // preamble: 7 bytes, low word plus 24 upper bits
  localparam int PRE_W    = 56;
  localparam int PRE_HI_W = 24;
  localparam logic [55:0] PRE_STD = 56'h55555555555555;

  // fcs
  localparam int          FCS_BYTES   = 4;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

  // histogram edges
  localparam logic [13:0] LEN_64   = 14'd64;
  localparam logic [13:0] LEN_127  = 14'd127;
  localparam logic [13:0] LEN_255  = 14'd255;
  localparam logic [13:0] LEN_511  = 14'd511;
  localparam logic [13:0] LEN_1023 = 14'd1023;
  localparam logic [13:0] LEN_1518 = 14'd1518;
  localparam logic [13:0] LEN_1522 = 14'd1522;

  // code word carried on the transmit output
  typedef enum logic [1:0] {
    ETC_CODE_IDLE = 2'b00,
    ETC_CODE_DATA = 2'b01,
    ETC_CODE_LFI  = 2'b10,
    ETC_CODE_RFI  = 2'b11
  } etc_code_t;

  // per-cycle statistic increments
  typedef struct packed {
    logic        total_packets;
    logic [4:0]  total_bytes;
    logic        good_packets;
    logic [13:0] good_bytes;
    logic        bad_fcs;
    logic        bin_64;
    logic        bin_65_127;
    logic        bin_128_255;
    logic        bin_256_511;
    logic        bin_512_1023;
    logic        bin_1024_1518;
    logic        bin_1519_1522;
  } etc_stat_t;
endpackage : etc_pkg

/* File: etc_crc32.sv */
// module: running ethernet crc over one beat of up to N bytes
`timescale 1ns/1ps
`default_nettype none
module etc_crc32 #(
  parameter int NBYTES = 16
) (
  // beat in
  input  wire logic [31:0]         i_crc,
  input  wire logic [NBYTES*8-1:0] i_data,
  input  wire logic [NBYTES-1:0]   i_keep,
  // updated crc
  output logic      [31:0]         o_crc
);
  initial begin
    if (NBYTES < 1) begin
      $error("etc_crc32: NBYTES must be positive");
    end
  end

  // bytes taken lsb first; keep is assumed contiguous from lane 0
  always_comb begin
    logic [31:0] c;
    c = i_crc;
    for (int b = 0; b < NBYTES; b++) begin
      if (i_keep[b]) begin
        c = c ^ {24'h000000, i_data[b*8 +: 8]};
        for (int k = 0; k < 8; k++) begin
          c = c[0] ? ((c >> 1) ^ etc_pkg::CRC_POLY) : (c >> 1);
        end
      end
    end
    o_crc = c;
  end
endmodule : etc_crc32
`default_nettype wire

/* File: etc_axil.sv */
// module: axi4-lite slave front end producing register strobes
`timescale 1ns/1ps
`default_nettype none
module etc_axil #(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // axi4-lite
  input  wire logic [AW-1:0] i_awaddr,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  output logic [1:0]         o_bresp,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  input  wire logic [AW-1:0] i_araddr,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  // register side
  output logic               o_wr,
  output logic [AW-1:0]      o_wr_addr,
  output logic [31:0]        o_wr_data,
  output logic [3:0]         o_wr_strb,
  input  wire logic          i_wr_err,
  output logic               o_rd,
  output logic [AW-1:0]      o_rd_addr,
  input  wire logic [31:0]   i_rd_data,
  input  wire logic          i_rd_err
);
  wire  aw_full = ~o_awready;
  wire  w_full  = ~o_wready;
  wire  aw_take = i_awvalid & o_awready;
  wire  w_take  = i_wvalid & o_wready;
  wire  do_wr   = aw_full & w_full & ~o_bvalid;

  assign o_wr      = do_wr;
  assign o_rd      = i_arvalid & ~o_rvalid;
  assign o_rd_addr = i_araddr;

  // address and data taken in either order, held until both are present
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_wr_addr <= '0;
      o_wr_data <= 32'h00000000;
      o_wr_strb <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      if (aw_take) begin
        o_awready <= 1'b0;
        o_wr_addr <= i_awaddr;
      end
      if (w_take) begin
        o_wready  <= 1'b0;
        o_wr_data <= i_wdata;
        o_wr_strb <= i_wstrb;
      end
      if (do_wr) begin
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
        o_bvalid <= 1'b1;
        o_bresp  <= i_wr_err ? 2'h2 : 2'h0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
      o_rdata   <= 32'h00000000;
      o_rresp   <= 2'h0;
    end else if (o_rd) begin
      o_rvalid  <= 1'b1;
      o_arready <= 1'b0;
      o_rdata   <= i_rd_data;
      o_rresp   <= i_rd_err ? 2'h2 : 2'h0;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule : etc_axil
`default_nettype wire

/* File: etc_sva.sv */
// checker: stream and statistics properties at the etc_top ports
`timescale 1ns/1ps
`default_nettype none
module etc_sva #(
  parameter int DATA_W = 128
) (
  // clock and reset
  input wire logic                i_clk,
  input wire logic                i_rst_n,
  // client stream
  input wire logic                i_s_valid,
  input wire logic                o_s_ready,
  input wire logic [DATA_W/8-1:0] i_s_keep,
  input wire logic                i_s_last,
  // transmit side and statistics
  input wire etc_pkg::etc_code_t  o_tx_code,
  input wire logic                o_tx_sop,
  input wire logic                o_tx_last,
  input wire logic                o_tx_fcs_append,
  input wire logic                o_tx_fcs_stomped,
  input wire etc_pkg::etc_stat_t  o_stat
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire take = i_s_valid && o_s_ready;

  a_stat_reset: assert property (disable iff (1'b0) !i_rst_n |=> o_stat == '0)
    else $error("statistics not cleared in reset");
  a_pkt_last: assert property (take && i_s_last |=> o_stat.total_packets && o_tx_last)
    else $error("packet count missing at last word");
  a_good_total: assert property (o_stat.good_packets |-> o_stat.total_packets)
    else $error("good packet without total packet");
  a_one_bin: assert property ($countones(o_stat[6:0]) == o_stat.total_packets)
    else $error("size bins not one per packet");
  a_good_bytes: assert property (o_stat.good_bytes != '0 |-> o_stat.good_packets)
    else $error("good bytes outside good packet end");
  a_beat_bytes: assert property (take && !i_s_last |=>
    o_stat.total_bytes == $countones($past(i_s_keep)))
    else $error("byte count differs from beat");
  a_idle_quiet: assert property (o_tx_code == etc_pkg::ETC_CODE_IDLE |->
    !o_tx_sop && !o_tx_last)
    else $error("frame word while idle");
  a_append_last: assert property (o_tx_fcs_append |-> o_tx_last && !o_tx_fcs_stomped)
    else $error("checksum append misplaced");
  a_bad_len: assert property (o_stat.bad_fcs |-> o_stat.total_packets && !o_stat.bin_64)
    else $error("bad checksum count on short packet");
endmodule : etc_sva

bind etc_top etc_sva #(.DATA_W(DATA_W)) u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_s_valid(i_s_valid), .o_s_ready(o_s_ready), .i_s_keep(i_s_keep), .i_s_last(i_s_last),
  .o_tx_code(o_tx_code), .o_tx_sop(o_tx_sop), .o_tx_last(o_tx_last),
  .o_tx_fcs_append(o_tx_fcs_append), .o_tx_fcs_stomped(o_tx_fcs_stomped), .o_stat(o_stat));
`default_nettype wire

/* File: etc_client.sv */
// model: client logic feeding the transmit stream
`timescale 1ns/1ps
`default_nettype none
module etc_client (
  // clock
  input wire logic    i_clk,
  // stream
  input wire logic    i_ready,
  output var logic    o_valid,
  output var logic [127:0] o_data,
  output var logic [15:0]  o_keep,
  output var logic    o_last
);
  initial begin
    o_valid = 1'b0;
    o_data = '0;
    o_keep = '0;
    o_last = 1'b0;
  end

  // data depends on length so no frame carries a valid checksum by chance
  task automatic send(input int n);
    logic r;
    while (n > 0) begin
      o_valid <= 1'b1;
      o_data <= {16{8'h5a}} ^ {4{n}};
      o_keep <= (n >= 16) ? 16'hffff : 16'hffff >> (16 - n);
      o_last <= (n <= 16);
      do begin
        @(negedge i_clk);
        r = i_ready;
        @(posedge i_clk);
      end while (!r);
      n -= 16;
    end
    o_valid <= 1'b0;
    o_last <= 1'b0;
    o_keep <= '0;
    o_data <= ~o_data;
  endtask : send
endmodule : etc_client
`default_nettype wire

/* File: tb_top.sv */
// testbench: registers, histogram, checksum, interrupt, preamble, codes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, irq, sop, tlast, app, stomp, s_valid, s_ready, s_last, stp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lresp;
  logic [127:0] s_data;
  logic [15:0] s_keep;
  logic [55:0] pre_out, pre;
  logic [127:0] tdat, sd;
  logic [31:0] tfcs, fcs;
  logic [15:0] tkp, sk;
  logic sb, apd;
  etc_pkg::etc_code_t code;
  etc_pkg::etc_stat_t stat, cap;
  int npk = 0, failures = 0, comparisons = 0;
  int tbl[13] = '{60, 61, 123, 124, 251, 252, 507, 508, 1019, 1020, 1514, 1515, 1518};

  etc_top #(.DATA_W(128)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_s_valid(s_valid), .o_s_ready(s_ready), .i_s_data(s_data), .i_s_keep(s_keep),
    .i_s_last(s_last), .o_tx_code(code), .o_tx_data(tdat), .o_tx_keep(tkp), .o_tx_sop(sop),
    .o_tx_last(tlast), .o_tx_preamble(pre_out), .o_tx_fcs_append(app), .o_tx_fcs(tfcs),
    .o_tx_fcs_stomped(stomp), .o_stat(stat), .o_irq(irq));
  etc_client cli (.i_clk(clk), .i_ready(s_ready), .o_valid(s_valid), .o_data(s_data),
    .o_keep(s_keep), .o_last(s_last));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (stat.total_packets) begin
      cap <= stat;
      stp <= stomp;
      apd <= app;
      fcs <= tfcs;
      npk <= npk + 1;
    end
    if (sop) pre <= pre_out;
    sb <= s_valid & s_ready;
    sd <= s_data;
    sk <= s_keep;
    if (sb) begin
      chk(tdat, sd);
      chk(tkp, sk);
    end
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      lresp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      rd_d = rdata;
      lresp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    chk(rd_d, e);
  endtask : rchk

  function automatic logic [6:0] binx(input int n);
    return n == 64 ? 7'h40 : n < 128 ? 7'h20 : n < 256 ? 7'h10 : n < 512 ? 7'h08 :
           n < 1024 ? 7'h04 : n < 1519 ? 7'h02 : 7'h01;
  endfunction : binx

  function automatic logic [31:0] crcx(input int n);
    logic [31:0] c;
    logic [127:0] d;
    c = etc_pkg::CRC_INIT;
    for (int i = 0; i < n; i++) begin
      if (i % 16 == 0) d = {16{8'h5a}} ^ {4{n - i}};
      c ^= d[i % 16 * 8 +: 8];
      repeat (8) c = c[0] ? c >> 1 ^ etc_pkg::CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crcx

  // n bytes sent, tot bytes counted (fcs included when appended)
  task automatic pk(input int n, input int tot, input logic g, input logic b, input logic s);
    int n0;
    n0 = npk;
    @(posedge clk);
    cli.send(n);
    repeat (3) @(negedge clk);
    chk(npk - n0, 1);
    chk(cap[6:0], binx(tot));
    chk(cap.good_packets, g);
    chk(cap.good_bytes, g ? tot : 0);
    chk(cap.bad_fcs, b);
    chk(stp, s);
    chk(apd, tot != n);
    chk(fcs, tot != n ? crcx(n) : 0);
  endtask : pk

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial begin
    #100us;
    failures++;
    end_sim;
  end

  initial begin
    static etc_pkg::etc_code_t ce[3] = '{etc_pkg::ETC_CODE_LFI, etc_pkg::ETC_CODE_RFI,
                                   etc_pkg::ETC_CODE_IDLE};
    static logic [31:0] cv[3] = '{32'h13, 32'h12, 32'h16};
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(etc_pkg::ADDR_CTRL, 32'h10);
    rchk(etc_pkg::ADDR_PRE_LO, 32'h55555555);
    rchk(etc_pkg::ADDR_PRE_HI, 32'h555555);
    rchk(8'h18, 32'h0);
    chk(lresp, 2'h2);
    $display("test registers done");
    foreach (tbl[i]) pk(tbl[i], tbl[i] + 4, 1'b1, 1'b0, 1'b0);
    wr(etc_pkg::ADDR_CTRL, 32'h30);
    pk(100, 104, 1'b1, 1'b0, 1'b0);
    wr(etc_pkg::ADDR_CTRL, 32'h0);
    pk(64, 64, 1'b0, 1'b0, 1'b1);
    pk(100, 100, 1'b0, 1'b1, 1'b1);
    wr(etc_pkg::ADDR_CTRL, 32'h20);
    pk(100, 100, 1'b1, 1'b1, 1'b1);
    $display("test histogram and checksum done");
    rchk(etc_pkg::ADDR_STATUS, 32'h3);
    rchk(etc_pkg::ADDR_STATUS, 32'h0);
    wr(etc_pkg::ADDR_MASK, 32'h1);
    wr(etc_pkg::ADDR_CTRL, 32'h10);
    pk(70, 74, 1'b1, 1'b0, 1'b0);
    chk(irq, 1'b1);
    rchk(etc_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    $display("test interrupt done");
    wr(etc_pkg::ADDR_PRE_LO, 32'h01234567);
    wr(etc_pkg::ADDR_PRE_HI, 32'h89abcd);
    wr(etc_pkg::ADDR_CTRL, 32'h18);
    pk(64, 68, 1'b1, 1'b0, 1'b0);
    chk(pre, 56'h89abcd01234567);
    wr(etc_pkg::ADDR_CTRL, 32'h10);
    pk(64, 68, 1'b1, 1'b0, 1'b0);
    chk(pre, 56'h55555555555555);
    $display("test preamble done");
    for (int i = 0; i < 3; i++) begin
      wr(etc_pkg::ADDR_CTRL, cv[i]);
      repeat (3) @(negedge clk);
      chk(code, ce[i]);
      chk(s_ready, 1'b0);
    end
    $display("test codes done");
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
